// ---- tb/pwoc_stage_model.sv ----
`timescale 1ns/1ps
// Power stage: a gate conducts only while its pin is actively driven high
module pwoc_stage_model (
   input  wire logic [5:0] pinOut,
   input  wire logic [5:0] pinOe,
   output logic      [5:0] gateDrive
);
   assign gateDrive = pinOut & pinOe;
endmodule // pwoc_stage_model

// ---- tb/pwoc_top_props.sv ----
`timescale 1ns/1ps
module pwoc_top_props #(
   parameter PAIRS = 3
) (
   input wire logic                 clk,
   input wire logic                 rst_n,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire logic [31:0]          prdata,
   input wire logic [2*PAIRS-1:0]   pwmRaw,
   input wire logic [2*PAIRS-1:0]   gpioOe,
   input wire logic [2*PAIRS-1:0]   pinOut,
   input wire logic [2*PAIRS-1:0]   pinOe,
   input wire logic [2*PAIRS-1:0]   pwmPinOwned,
   input wire logic [PAIRS-1:0]     pairIndependent
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_answer; pready ##1 !pready; endsequence
   // Mode changes land over a cycle, so pins are judged only when both are settled
   sequence s_steady; $past(rst_n) && $stable(pwmPinOwned) && $stable(pairIndependent); endsequence
   property p_answer; $rose(psel && penable) |=> s_answer; endproperty
   property p_refuse; pslverr |-> pready && prdata == 32'h0; endproperty
   property p_mask; pwmPinOwned inside {6'h00, 6'h02, 6'h03, 6'h0F, 6'h3F}; endproperty
   property p_owned; (pinOe & pwmPinOwned) == pwmPinOwned; endproperty
   property p_comp0; s_steady ##0 (pwmPinOwned[1] && !pairIndependent[0]) |-> pinOut[1] == !$past(pwmRaw[0]);
   endproperty
   property p_ind0; s_steady ##0 (pwmPinOwned[1] && pairIndependent[0]) |-> pinOut[1] == $past(pwmRaw[1]);
   endproperty
   property p_comp1; s_steady ##0 (pwmPinOwned[3] && !pairIndependent[1]) |-> pinOut[3] == !$past(pwmRaw[2]);
   endproperty
   property p_ind2; s_steady ##0 (pwmPinOwned[5] && pairIndependent[2]) |-> pinOut[5] == $past(pwmRaw[5]);
   endproperty
   property p_ind1; s_steady ##0 (pwmPinOwned[3] && pairIndependent[1]) |-> pinOut[3] == $past(pwmRaw[3]);
   endproperty
   property p_comp2; s_steady ##0 (pwmPinOwned[5] && !pairIndependent[2]) |-> pinOut[5] == !$past(pwmRaw[4]);
   endproperty
   property p_gpio; s_steady |-> (pinOe & ~pwmPinOwned) == ($past(gpioOe) & ~pwmPinOwned); endproperty
   a_answer: assert property (p_answer) else $error("access not answered by one pready pulse");
   a_refuse: assert property (p_refuse) else $error("error response without pready or with data");
   a_mask:   assert property (p_mask) else $error("illegal pin ownership mask");
   a_owned:  assert property (p_owned) else $error("owned pin not driven");
   a_comp0:  assert property (p_comp0) else $error("pair 0 not complementary");
   a_ind0:   assert property (p_ind0) else $error("pair 0 not independent");
   a_comp1:  assert property (p_comp1) else $error("pair 1 not complementary");
   a_ind2:   assert property (p_ind2) else $error("pair 2 not independent");
   a_ind1:   assert property (p_ind1) else $error("pair 1 not independent");
   a_comp2:  assert property (p_comp2) else $error("pair 2 not complementary");
   a_gpio:   assert property (p_gpio) else $error("free pin enable not from gpio");
endmodule // pwoc_top_props

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
   logic clk = 0, rst_n = 0, cfg = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic [5:0] pwmRaw = 6'h3F, gpioOut = 6'h2A, gpioOe = 6'h15, pinOut, pinOe, owned, gate;
   logic [2:0] ind;
   int num_errors = 0, cmp_count = 0, cycles = 0, i;
   initial forever #12.5 clk = ~clk;
   pwoc_top i_pwoc_top (.clk(clk), .rst_n(rst_n), .powerUpPinOwnerConfig(cfg), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pwmRaw(pwmRaw), .gpioOut(gpioOut), .gpioOe(gpioOe), .pinOut(pinOut), .pinOe(pinOe),
      .pwmPinOwned(owned), .pairIndependent(ind));
   pwoc_stage_model i_pwoc_stage_model (.pinOut(pinOut), .pinOe(pinOe), .gateDrive(gate));
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // Waits for pready however long it takes; only the bench timeout ends a hung access
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task doReset(input logic c);
      rst_n <= 0; cfg <= c;
      repeat (5) @(posedge clk);
      rst_n <= 1;
      repeat (2) @(posedge clk);
   endtask
   function logic [5:0] maskOf(input logic [2:0] c);
      return c[2] ? 6'h3F : c == 3 ? 6'h0F : c == 2 ? 6'h03 : c == 1 ? 6'h02 : 6'h00;
   endfunction
   task results;
      $display("TB: %0d checks, %0d mismatches", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         $display("MISMATCH timeout expected 0 seen 1");
         results;
      end
   end
   initial begin
      doReset(1);
      chk("owned", 32'h0, owned);
      xfer(0, 12'h000, 0); chk("ctrl", 32'h0, rd);
      xfer(0, 12'h004, 0); chk("status", 32'h10000, rd);
      doReset(0);
      chk("owned", 32'h3F, owned);
      xfer(0, 12'h000, 0); chk("ctrl", 32'h70, rd);
      $display("TB: reset test done");
      for (i = 0; i < 8; i++) begin
         xfer(1, 12'h000, i << 4); xfer(0, 12'h000, 0);
         chk("ctrl", i << 4, rd);
         chk("owned", maskOf(i[2:0]), owned);
      end
      $display("TB: pin assign test done");
      // All raw high: complementary odd pins go low, independent ones follow high
      for (i = 0; i < 3; i++) begin
         xfer(1, 12'h000, 32'h70 | (1 << i)); repeat (3) @(posedge clk);
         chk("mode", 1 << i, ind);
         chk("gate", 6'h15 | (6'h2 << 2 * i), gate);
      end
      // Low raw inputs show the inversion of complementary odd pins
      pwmRaw <= 6'h00;
      xfer(1, 12'h000, 32'h70); repeat (3) @(posedge clk);
      chk("gate", 32'h2A, gate);
      // Even high, odd low: independent odd pins must follow their own raw input
      pwmRaw <= 6'h15;
      xfer(1, 12'h000, 32'h77); repeat (3) @(posedge clk);
      chk("gate", 32'h15, gate);
      pwmRaw <= 6'h3F;
      $display("TB: pair mode test done");
      xfer(1, 12'h000, 32'hFF); xfer(0, 12'h000, 0); chk("ctrl", 32'h77, rd);
      xfer(1, 12'h000, 32'h10); repeat (3) @(posedge clk);
      chk("pinOe", 32'h17, pinOe);
      chk("pinOut", 32'h28, pinOut);
      xfer(1, 12'h000, 32'h35);
      xfer(1, 12'h004, 32'hFFFF); chk("slverr", 0, err);
      xfer(0, 12'h004, 0);
      chk("status", 32'h50F, rd);
      // A write without the low byte strobe must leave the control register alone
      pstrb <= 4'hE;
      xfer(1, 12'h000, 32'h0);
      pstrb <= 4'hF;
      xfer(0, 12'h000, 0); chk("ctrl", 32'h35, rd);
      xfer(0, 12'h008, 0); chk("slverr", 1, err);
      chk("rdata", 0, rd);
      $display("TB: access test done");
      results;
   end
endmodule // tb
bind pwoc_top pwoc_top_props #(.PAIRS(PAIRS)) i_pwoc_top_props (.clk(clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .pwmRaw(pwmRaw), .gpioOe(gpioOe),
   .pinOut(pinOut), .pinOe(pinOe), .pwmPinOwned(pwmPinOwned), .pairIndependent(pairIndependent));

// ---- verilog/pwoc_consts.vh ----
`ifndef PWOC_CONSTS_VH
`define PWOC_CONSTS_VH

`define PWOC_ADDR_CTRL       12'h000
`define PWOC_ADDR_STATUS     12'h004

`define PWOC_MODE_LSB        0
`define PWOC_MODE_MSB        2
`define PWOC_ASSIGN_LSB      4
`define PWOC_ASSIGN_MSB      6
`define PWOC_ASSIGN_TOP      6
`define PWOC_CTRL_MASK       8'h77

`define PWOC_CODE_NONE       3'h0
`define PWOC_CODE_SECOND     3'h1
`define PWOC_CODE_TWO        3'h2
`define PWOC_CODE_FOUR       3'h3

`define PWOC_MASK_NONE       6'h00
`define PWOC_MASK_SECOND     6'h02
`define PWOC_MASK_TWO        6'h03
`define PWOC_MASK_FOUR       6'h0F
`define PWOC_MASK_ALL        6'h3F

`define PWOC_MODE_RESET      3'h0
`define PWOC_ASSIGN_RST_ON   3'h7
`define PWOC_ASSIGN_RST_OFF  3'h0

`define PWOC_STAT_OWN_LSB    0
`define PWOC_STAT_IND_LSB    8
`define PWOC_STAT_CFG_BIT    16

`endif

// ---- verilog/pwoc_pin_mux.v ----
`timescale 1ns/1ps
`include "pwoc_consts.vh"

module pwoc_pin_mux #(
   parameter PAIRS = 3
) (
   input  wire [2*PAIRS-1:0] ownMask,
   input  wire [PAIRS-1:0]   pairIndependent,
   input  wire [2*PAIRS-1:0] pwmRaw,
   input  wire [2*PAIRS-1:0] gpioOut,
   input  wire [2*PAIRS-1:0] gpioOe,
   output wire [2*PAIRS-1:0] pinOutNext,
   output wire [2*PAIRS-1:0] pinOeNext
);

   genvar p;
   generate
      for (p = 0; p < PAIRS; p = p + 1) begin : gPair
         wire evenPwm;
         wire oddPwm;
         assign evenPwm = pwmRaw[2*p];
         // Complementary pairs take the odd output from the even generator so the two never agree while both pins of the pair are owned
         assign oddPwm  = pairIndependent[p] ? pwmRaw[2*p+1] : ~pwmRaw[2*p];
         assign pinOutNext[2*p]   = ownMask[2*p]   ? evenPwm : gpioOut[2*p];
         assign pinOutNext[2*p+1] = ownMask[2*p+1] ? oddPwm  : gpioOut[2*p+1];
         assign pinOeNext[2*p]    = ownMask[2*p]   | gpioOe[2*p];
         assign pinOeNext[2*p+1]  = ownMask[2*p+1] | gpioOe[2*p+1];
      end
   endgenerate

endmodule // pwoc_pin_mux

// ---- verilog/pwoc_top.v ----
`timescale 1ns/1ps
`include "pwoc_consts.vh"

module pwoc_top #(
   parameter PAIRS = 3,
   parameter ADDR_W = 12
) (
   input  wire               clk,
   input  wire               rst_n,
   input  wire               powerUpPinOwnerConfig,
   input  wire               psel,
   input  wire               penable,
   input  wire               pwrite,
   input  wire [ADDR_W-1:0]  paddr,
   input  wire [31:0]        pwdata,
   input  wire [3:0]         pstrb,
   output reg  [31:0]        prdata,
   output reg                pready,
   output reg                pslverr,
   input  wire [2*PAIRS-1:0] pwmRaw,
   input  wire [2*PAIRS-1:0] gpioOut,
   input  wire [2*PAIRS-1:0] gpioOe,
   output reg  [2*PAIRS-1:0] pinOut,
   output reg  [2*PAIRS-1:0] pinOe,
   output reg  [2*PAIRS-1:0] pwmPinOwned,
   output reg  [PAIRS-1:0]   pairIndependent
);

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_RESP = 3'h2;
   localparam [2:0] ST_HOLD = 3'h4;

   reg  [2:0]         state_reg;
   reg  [2:0]         state_next;
   reg  [2:0]         pinAssign_reg;
   reg  [2:0]         pinAssign_next;
   reg  [2:0]         pairMode_reg;
   reg  [2:0]         pairMode_next;
   reg                cfgSeen_reg;
   reg  [2*PAIRS-1:0] ownMask;
   reg  [31:0]        readData;
   reg                addrHit;
   wire [7:0]         ctrlByte;
   wire [2*PAIRS-1:0] pinOutNext;
   wire [2*PAIRS-1:0] pinOeNext;
   wire               accessReq;
   wire               writeFire;

   // A request is in its access phase
   assign accessReq = psel & penable;

   // Write lands only on the edge where the master sees pready high
   assign writeFire = (state_reg == ST_RESP) & accessReq & pwrite & pstrb[0];

   // Reserved bits 7 and 3 read back as zero
   assign ctrlByte = {1'b0, pinAssign_reg, 1'b0, pairMode_reg};

   // Pin assignment decode
   always @* begin
      case (pinAssign_reg)
         `PWOC_CODE_NONE: begin
            ownMask = `PWOC_MASK_NONE;
         end
         `PWOC_CODE_SECOND: begin
            ownMask = `PWOC_MASK_SECOND;
         end
         `PWOC_CODE_TWO: begin
            ownMask = `PWOC_MASK_TWO;
         end
         `PWOC_CODE_FOUR: begin
            ownMask = `PWOC_MASK_FOUR;
         end
         default: begin
            // Any code with the top bit set hands every output over
            ownMask = `PWOC_MASK_ALL;
         end
      endcase
   end

   // Address decode and read data
   always @* begin
      addrHit  = 1'b0;
      readData = 32'h0000_0000;
      case (paddr)
         `PWOC_ADDR_CTRL: begin
            addrHit  = 1'b1;
            readData = {24'h00_0000, ctrlByte};
         end
         `PWOC_ADDR_STATUS: begin
            addrHit  = 1'b1;
            readData[`PWOC_STAT_OWN_LSB +: 2*PAIRS] = pwmPinOwned;
            readData[`PWOC_STAT_IND_LSB +: PAIRS]   = pairIndependent;
            readData[`PWOC_STAT_CFG_BIT]            = cfgSeen_reg;
         end
         default: begin
            addrHit  = 1'b0;
            readData = 32'h0000_0000;
         end
      endcase
   end

   // Bus state machine: one wait cycle, then pready for one cycle
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (accessReq) begin
               state_next = ST_RESP;
            end
         end
         ST_RESP: begin
            state_next = ST_HOLD;
         end
         ST_HOLD: begin
            // Lets the master drop penable before a new access is seen
            state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Control register next value
   always @* begin
      pinAssign_next = pinAssign_reg;
      pairMode_next  = pairMode_reg;
      if (writeFire && (paddr == `PWOC_ADDR_CTRL)) begin
         // Bits 7 and 3 are dropped, so they cannot be written
         pinAssign_next = pwdata[`PWOC_ASSIGN_MSB:`PWOC_ASSIGN_LSB];
         pairMode_next  = pwdata[`PWOC_MODE_MSB:`PWOC_MODE_LSB];
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Reset is synchronous, so the configuration bit is sampled by this clocked process
   always @(posedge clk) begin
      if (!rst_n) begin
         if (powerUpPinOwnerConfig) begin
            pinAssign_reg <= `PWOC_ASSIGN_RST_OFF;
         end else begin
            pinAssign_reg <= `PWOC_ASSIGN_RST_ON;
         end
         pairMode_reg <= `PWOC_MODE_RESET;
         cfgSeen_reg  <= powerUpPinOwnerConfig;
      end else begin
         pinAssign_reg <= pinAssign_next;
         pairMode_reg  <= pairMode_next;
      end
   end

   // Bus answer
   always @(posedge clk) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         if ((state_reg == ST_IDLE) && accessReq) begin
            pready  <= 1'b1;
            pslverr <= ~addrHit;
            if (!pwrite) begin
               prdata <= readData;
            end else begin
               prdata <= 32'h0000_0000;
            end
         end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
         end
      end
   end

   pwoc_pin_mux #(
      .PAIRS           (PAIRS)
   ) uPinMux (
      .ownMask         (ownMask),
      .pairIndependent (pairMode_reg),
      .pwmRaw          (pwmRaw),
      .gpioOut         (gpioOut),
      .gpioOe          (gpioOe),
      .pinOutNext      (pinOutNext),
      .pinOeNext       (pinOeNext)
   );

   // Pins are registered, so a control write reaches them one cycle later
   always @(posedge clk) begin
      if (!rst_n) begin
         pinOut          <= {2*PAIRS{1'b0}};
         pinOe           <= {2*PAIRS{1'b0}};
         pwmPinOwned     <= {2*PAIRS{1'b0}};
         pairIndependent <= {PAIRS{1'b0}};
      end else begin
         pinOut          <= pinOutNext;
         pinOe           <= pinOeNext;
         pwmPinOwned     <= ownMask;
         pairIndependent <= pairMode_reg;
      end
   end

endmodule // pwoc_top
